// >>> rtl/sfl_master.sv
// Master end: drives strobes and output enable, moves bytes both ways
`timescale 1ns/1ps
`default_nettype none
module sfl_master
  import sfl_pkg::*;
#(
  parameter bit RST_HIGH = RST_HIGH_DEF
) (
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,      // Raw reset; polarity set by RST_HIGH
  sfl_link_if.master             link,        // RL14
  output logic                   rd_valid_o,  // Byte read from the slave
  output logic [DATA_W-1:0]      rd_data_o,
  input  wire logic              wr_valid_i,  // Byte to write to the slave
  input  wire logic [DATA_W-1:0] wr_data_i,
  output logic                   wr_ready_o,
  input  wire logic              send_now_i,  // Request a send/wakeup strobe
  output logic                   seq_err_o    // Pulse: byte not previous plus one
);
  typedef enum logic [1:0] {M_IDLE, M_TURN, M_READ, M_WRITE} sfl_mst_e;
  sfl_mst_e st_q, st_d;
  logic rst_act;
  logic [4:0] s1_q, s2_q;            // clk, rxf, txe synchronisers (+pad)
  logic clk_prev_q, rise;
  logic [DATA_W-1:0] d1_q, d2_q, wd_q, wd_d, last_q;
  logic oe_q, oe_d, rd_q, rd_d, wr_q, wr_d, doe_q, doe_d, si_q, si_d;
  logic have_last_q, take;
  logic wpend_q, wpend_d;            // Byte in wd_q refused by a full slave, resend first

  assign rst_act = RST_HIGH ? rstn_i : ~rstn_i;  // RL19
  assign rise = s2_q[0] & ~clk_prev_q;            // RL15 RL16

  // Link control: read, write, turnaround
  always_comb
  begin
    st_d = st_q; oe_d = oe_q; rd_d = rd_q; wr_d = wr_q; doe_d = doe_q; wd_d = wd_q;
    si_d = 1'b1; take = 1'b0;
    wpend_d = wpend_q;
    if (send_now_i) si_d = 1'b0;
    if (rise)
    begin
      case (st_q)
        M_IDLE:
        begin
          if (!s2_q[1])
          begin
            st_d = M_TURN; oe_d = 1'b0;               // RL5
          end
          else if (!s2_q[2] && (wpend_q || wr_valid_i))
          begin
            st_d = M_WRITE; wr_d = 1'b0; doe_d = 1'b1; wpend_d = 1'b0; // RL8
            if (!wpend_q)
              wd_d = wr_data_i;
          end
        end
        M_TURN:
        begin
          st_d = M_READ; rd_d = 1'b0;                 // RL6 RL9
        end
        M_READ:
        begin
          take = 1'b1;                                // RL10
          if (s2_q[1])
          begin
            st_d = M_IDLE; rd_d = 1'b1; oe_d = 1'b1;  // RL20
            take = 1'b0;
          end
        end
        M_WRITE:
        begin
          // Full seen late: the byte just loaded was refused, so keep it
          if (s2_q[2])
          begin
            st_d = M_IDLE; wr_d = 1'b1; doe_d = 1'b0; wpend_d = 1'b1; // RL20 RL2
          end
          else if (!wr_valid_i)
          begin
            st_d = M_IDLE; wr_d = 1'b1; doe_d = 1'b0; // RL20
          end
          else
            wd_d = wr_data_i;                         // RL11
        end
        default: st_d = M_IDLE;
      endcase
    end
  end

  assign wr_ready_o = rise & (((st_q == M_IDLE) & s2_q[1] & ~s2_q[2] & ~wpend_q) |
                      ((st_q == M_WRITE) & ~s2_q[2])) & wr_valid_i;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_act)
    begin
      st_q <= M_IDLE; oe_q <= 1'b1; rd_q <= 1'b1; wr_q <= 1'b1; doe_q <= 1'b0;
      si_q <= 1'b1; wd_q <= '0; s1_q <= 5'h06; s2_q <= 5'h06; clk_prev_q <= 1'b0;
      rd_valid_o <= 1'b0; rd_data_o <= '0; last_q <= '0; have_last_q <= 1'b0;
      seq_err_o <= 1'b0;
      wpend_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; oe_q <= oe_d; rd_q <= rd_d; wr_q <= wr_d; doe_q <= doe_d;
      si_q <= si_d; wd_q <= wd_d;
      wpend_q <= wpend_d;
      s1_q <= {2'b00, link.tx_space_avail_n, link.rx_data_avail_n, link.link_clk};
      s2_q <= s1_q; clk_prev_q <= s2_q[0];
      rd_valid_o <= take;
      seq_err_o <= 1'b0;
      if (take)
      begin
        rd_data_o <= d2_q;
        last_q <= d2_q; have_last_q <= 1'b1;
        seq_err_o <= have_last_q & (d2_q != last_q + CHK_STEP); // RL18
      end
    end
  end

  // Data bus synchroniser
  always_ff @(posedge core_clk_i)
  begin
    d1_q <= link.data;   // RL17
    d2_q <= d1_q;        // RL17
  end

  assign link.oe_n = oe_q;
  assign link.rd_n = rd_q;   // RL9
  assign link.wr_n = wr_q;   // RL9
  assign link.send_now_wakeup_n = si_q;
  assign link.m_data_oe = doe_q;
  assign link.m_data_o = wd_q;
endmodule : sfl_master
`default_nettype wire

// >>> rtl/sfl_pkg.sv
// Package: shared constants for the synchronous parallel FIFO link
package sfl_pkg;
  localparam int unsigned DATA_W       = 8;      // Shared data bus width
  localparam int unsigned CORE_CLK_HZ  = 10_000_000;
  localparam int unsigned LINK_CLK_HZ  = 60_000_000; // Nominal link clock rate
  localparam int unsigned LINK_DIV     = 2;      // Core cycles per link clock half period
  localparam int unsigned SLV_DEPTH    = 16;     // Slave transmit/receive storage depth
  localparam logic [7:0]  CHK_STEP     = 8'h01;  // Expected increment between bytes
  localparam bit          RST_HIGH_DEF = 1'b1;   // Master reset active high by default
endpackage : sfl_pkg

// >>> rtl/sfl_link_if.sv
// Interface: the pins between the slave end and the master end
`timescale 1ns/1ps
`default_nettype none
interface sfl_link_if;
  import sfl_pkg::*;
  logic              link_clk;          // Link clock, made by the slave
  logic              rx_data_avail_n;   // Slave has data for the master
  logic              tx_space_avail_n;  // Slave can accept data
  logic              rd_n;              // Read strobe, master driven
  logic              wr_n;              // Write strobe, master driven
  logic              oe_n;              // Turns slave data port to output
  logic              send_now_wakeup_n; // Send immediate / wakeup strobe
  logic [DATA_W-1:0] s_data_o;          // Slave data drive
  logic              s_data_oe;         // Slave drives the bus
  logic [DATA_W-1:0] m_data_o;          // Master data drive
  logic              m_data_oe;         // Master drives the bus
  logic [DATA_W-1:0] data;              // Resolved bus level

  // Bus resolution; only one side ever drives at a time
  assign data = s_data_oe ? s_data_o : (m_data_oe ? m_data_o : '0);

  modport slave (
    output link_clk, rx_data_avail_n, tx_space_avail_n, s_data_o, s_data_oe,
    input  rd_n, wr_n, oe_n, send_now_wakeup_n, data
  );
  modport master (
    input  link_clk, rx_data_avail_n, tx_space_avail_n, data,
    output rd_n, wr_n, oe_n, send_now_wakeup_n, m_data_o, m_data_oe
  );
endinterface : sfl_link_if
`default_nettype wire

// >>> rtl/sfl_slave.sv
// Slave end: makes the link clock, holds receive and transmit bytes
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1 - Slave generates link clock for all sampling
// RL2 - Data bus carries one direction at once
// RL3 - Data bus is eight bits, bidirectional
// RL4 - Receive available low while readable data held
// RL5 - Low output enable turns slave port outward
// RL6 - Master reads only after port turned outward
// RL7 - Transmit space low while slave accepts writes
// RL8 - Master writes only on transmit space low
// RL9 - Master alone drives both strobes
// RL10 - Read strobe low: byte taken, next presented
// RL11 - Write strobe low: slave takes byte
// RL12 - Wakeup strobe in suspend requests resume
// RL13 - Wakeup strobe otherwise flushes transmit buffer
// RL14 - Slaves exchange data only through master
// RL15 - Bridge reads on transmitting slave's clock
// RL16 - Bridge writes on receiving slave's clock
// RL17 - Bridge crosses domains through dual-clock buffer
// RL18 - Checker flags byte not previous plus one
// RL19 - Master reset polarity depends on load path
// RL20 - Master releases strobes when status goes high
module sfl_slave
  import sfl_pkg::*;
#(
  parameter int unsigned DEPTH = SLV_DEPTH,
  parameter int unsigned DIV   = LINK_DIV
) (
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  sfl_link_if.slave              link,
  input  wire logic              host_valid_i,   // USB side byte for the master
  input  wire logic [DATA_W-1:0] host_data_i,
  output logic                   host_ready_o,
  output logic                   tx_valid_o,     // Byte written by the master
  output logic [DATA_W-1:0]      tx_data_o,
  input  wire logic              tx_ready_i,
  input  wire logic              suspend_i,      // USB is in suspend
  input  wire logic              wake_en_i,      // Remote wakeup enabled
  input  wire logic              bulk_in_req_i,  // Host bulk-in request
  output logic                   resume_req_o,   // Pulse: ask for USB resume
  output logic                   flush_o         // Pulse: send buffered data now
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [7:0]  DIV_M1  = 8'(DIV - 1);

  logic [DATA_W-1:0] rx_mem [DEPTH]; // RL3
  logic [DATA_W-1:0] tx_mem [DEPTH];
  logic [AW:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
  logic [AW:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
  logic [7:0]  div_q, div_d;
  logic        clk_q, clk_d, rise;
  logic [2:0]  ctl_s1_q, ctl_s2_q;   // rd_n, wr_n, oe_n synchronisers
  logic [DATA_W-1:0] din_s1_q, din_s2_q;
  logic        si_s1_q, si_s2_q, si_prev_q, flush_pend_q, flush_pend_d;
  logic        rx_empty, tx_full, rd_go, wr_go, host_go, tx_go, si_fall;

  // Link clock divider; link edges are core events, so no second domain
  always_comb
  begin
    div_d = div_q + 8'h01;
    clk_d = clk_q;
    rise  = 1'b0;
    if (div_q == DIV_M1)
    begin
      div_d = 8'h00;
      clk_d = ~clk_q;
      rise  = ~clk_q;                  // RL1
    end
  end

  // Status and strobe decode
  assign rx_empty = (rx_wp_q == rx_rp_q);
  assign tx_full  = ((tx_wp_q - tx_rp_q) == DEPTH_C);
  assign rd_go    = rise & ~ctl_s2_q[0] & ~ctl_s2_q[2] & ~rx_empty; // RL10
  assign wr_go    = rise & ~ctl_s2_q[1] & ctl_s2_q[2] & ~tx_full;   // RL11
  assign host_go  = host_valid_i & host_ready_o;
  assign tx_go    = tx_valid_o & tx_ready_i;
  assign host_ready_o = ((rx_wp_q - rx_rp_q) != DEPTH_C);
  assign si_fall  = si_prev_q & ~si_s2_q;

  // Pointer updates
  always_comb
  begin
    rx_wp_d = rx_wp_q + (AW+1)'(host_go);
    rx_rp_d = rx_rp_q + (AW+1)'(rd_go);
    tx_wp_d = tx_wp_q + (AW+1)'(wr_go);
    tx_rp_d = tx_rp_q + (AW+1)'(tx_go);
    flush_pend_d = flush_pend_q;
    if (si_fall & ~suspend_i)
      flush_pend_d = 1'b1;             // RL13
    else if (bulk_in_req_i)
      flush_pend_d = 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      div_q <= 8'h00; clk_q <= 1'b0;
      rx_wp_q <= '0; rx_rp_q <= '0; tx_wp_q <= '0; tx_rp_q <= '0;
      ctl_s1_q <= 3'h7; ctl_s2_q <= 3'h7;
      si_s1_q <= 1'b1; si_s2_q <= 1'b1; si_prev_q <= 1'b1;
      flush_pend_q <= 1'b0;
      resume_req_o <= 1'b0; flush_o <= 1'b0;
    end
    else
    begin
      div_q <= div_d; clk_q <= clk_d;
      rx_wp_q <= rx_wp_d; rx_rp_q <= rx_rp_d;
      tx_wp_q <= tx_wp_d; tx_rp_q <= tx_rp_d;
      ctl_s1_q <= {link.oe_n, link.wr_n, link.rd_n};
      ctl_s2_q <= ctl_s1_q;
      si_s1_q <= link.send_now_wakeup_n; si_s2_q <= si_s1_q; si_prev_q <= si_s2_q;
      flush_pend_q <= flush_pend_d;
      resume_req_o <= si_fall & suspend_i & wake_en_i;  // RL12
      flush_o <= flush_pend_q & bulk_in_req_i;           // RL13
    end
  end

  // Data bus sampling; no reset needed on the data path
  always_ff @(posedge core_clk_i)
  begin
    din_s1_q <= link.data;
    din_s2_q <= din_s1_q;
    if (host_go)
      rx_mem[rx_wp_q[AW-1:0]] <= host_data_i;
    if (wr_go)
      tx_mem[tx_wp_q[AW-1:0]] <= din_s2_q; // RL11
  end

  // Pin outputs
  assign link.link_clk         = clk_q;
  assign link.rx_data_avail_n  = rx_empty;          // RL4
  assign link.tx_space_avail_n = tx_full;           // RL7
  assign link.s_data_oe        = ~ctl_s2_q[2];      // RL5 RL2
  assign link.s_data_o         = rx_mem[rx_rp_q[AW-1:0]]; // RL10
  assign tx_valid_o            = (tx_wp_q != tx_rp_q);
  assign tx_data_o             = tx_mem[tx_rp_q[AW-1:0]];
endmodule : sfl_slave
`default_nettype wire

// >>> dv/sfl_link_props.sv
// Checker: pin relations on the link between the slave and master ends
`timescale 1ns/1ps
`default_nettype none
module sfl_link_props (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic link_clk,
  input wire logic rx_data_avail_n,
  input wire logic tx_space_avail_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic s_data_oe,
  input wire logic m_data_oe
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Ends sample through two flops, so direction follows output enable late
  sequence s_half;
    $stable(link_clk) ##1 $changed(link_clk);
  endsequence
  sequence s_oe_lo;
    (!oe_n)[*4];
  endsequence
  sequence s_oe_hi;
    oe_n[*4];
  endsequence

  property p_clk_half;
    $changed(link_clk) |=> s_half;
  endproperty
  property p_one_drv;
    !(s_data_oe && m_data_oe);
  endproperty
  property p_oe_in;
    s_oe_hi |-> !s_data_oe;
  endproperty
  property p_rd_after_oe;
    $fell(rd_n) |-> !oe_n && $past(!oe_n);
  endproperty
  property p_wr_space;
    $fell(wr_n) |-> !tx_space_avail_n;
  endproperty
  property p_strobe_excl;
    rd_n || wr_n;
  endproperty
  property p_rd_drive;
    s_oe_lo |-> s_data_oe;
  endproperty
  property p_wr_drive;
    !wr_n |-> m_data_oe && oe_n;
  endproperty
  property p_rd_rel;
    $rose(rx_data_avail_n) |-> ##[0:16] (rd_n && oe_n);
  endproperty
  property p_wr_rel;
    $rose(tx_space_avail_n) |-> ##[0:16] wr_n;
  endproperty

  a_clk_half: assert property (p_clk_half)
    else $error("link clock half period is not two core cycles");
  a_one_drv: assert property (p_one_drv)
    else $error("both ends drive the data bus");
  a_oe_in: assert property (p_oe_in)
    else $error("slave drives with output enable high");
  a_rd_after_oe: assert property (p_rd_after_oe)
    else $error("read strobe before output enable");
  a_wr_space: assert property (p_wr_space)
    else $error("write strobe without space");
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("both strobes low");
  a_rd_drive: assert property (p_rd_drive)
    else $error("slave not driving while output enabled");
  a_wr_drive: assert property (p_wr_drive)
    else $error("master not driving while writing");
  a_rd_rel: assert property (p_rd_rel)
    else $error("read strobe held after data ran out");
  a_wr_rel: assert property (p_wr_rel)
    else $error("write strobe held after space ran out");
endmodule : sfl_link_props
`default_nettype wire

// >>> dv/test_sync_parallel_fifo_link.sv
// Testbench: two link ends face to face, traffic both ways, send-now
`timescale 1ns/1ps
`default_nettype none
module test_sync_parallel_fifo_link;
  import sfl_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic host_valid_i = 1'b0, tx_ready_i = 1'b1, suspend_i = 1'b0, wake_en_i = 1'b0;
  logic bulk_i = 1'b0, wr_valid_i = 1'b0, send_now_i = 1'b0;
  logic [DATA_W-1:0] host_data_i = '0, wr_data_i = '0, rd_data_o, tx_data_o;
  logic host_ready_o, tx_valid_o, resume_req_o, flush_o, rd_valid_o, wr_ready_o, seq_err_o;
  int n_mismatch = 0, checks_done = 0, n_seq = 0, n_flush = 0, n_res = 0;
  logic [DATA_W-1:0] rdq[$], txq[$];

  sfl_link_if lnk ();
  // Small depth so a short burst fills the slave
  sfl_slave #(.DEPTH(4)) u_sfl_slave (.core_clk_i, .rstn_i, .link(lnk), .host_valid_i,
    .host_data_i, .host_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .suspend_i,
    .wake_en_i, .bulk_in_req_i(bulk_i), .resume_req_o, .flush_o);
  // Low-active reset chosen so both ends share the bench reset
  sfl_master #(.RST_HIGH(1'b0)) u_sfl_master (.core_clk_i, .rstn_i, .link(lnk), .rd_valid_o,
    .rd_data_o, .wr_valid_i, .wr_data_i, .wr_ready_o, .send_now_i, .seq_err_o);
  sfl_link_props u_sfl_link_props (.core_clk_i, .rstn_i, .link_clk(lnk.link_clk),
    .rx_data_avail_n(lnk.rx_data_avail_n), .tx_space_avail_n(lnk.tx_space_avail_n),
    .rd_n(lnk.rd_n), .wr_n(lnk.wr_n), .oe_n(lnk.oe_n), .s_data_oe(lnk.s_data_oe),
    .m_data_oe(lnk.m_data_oe));

  always #50 core_clk_i = ~core_clk_i;

  // Falling edge sees what the next rising edge takes, free of races
  always @(negedge core_clk_i)
  begin
    if (rd_valid_o === 1'b1) rdq.push_back(rd_data_o);
    if (tx_valid_o === 1'b1 && tx_ready_i) txq.push_back(tx_data_o);
    n_seq += int'(seq_err_o === 1'b1);
    n_flush += int'(flush_o === 1'b1);
    n_res += int'(resume_req_o === 1'b1);
  end

  task automatic cmp(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Valid stays up between bytes; caller drops it after the last
  task automatic put(input bit mst, input logic [DATA_W-1:0] b);
    if (mst) {wr_valid_i, wr_data_i} <= {1'b1, b};
    else {host_valid_i, host_data_i} <= {1'b1, b};
    for (int i = 0; i < 3000; i++)
    begin
      @(negedge core_clk_i);
      if ((mst ? wr_ready_o : host_ready_o) === 1'b1) break;
    end
    @(posedge core_clk_i);
  endtask : put

  task automatic t_read();
    int s;
    put(0, 8'h10);
    host_valid_i <= 1'b0;
    @(negedge core_clk_i);
    cmp("rx avail", 8'h00, DATA_W'(lnk.rx_data_avail_n));
    for (int i = 0; i < 400 && rdq.size() < 1; i++) @(posedge core_clk_i);
    // Let the released strobe reach the slave, else a new byte is popped unseen
    repeat (20) @(posedge core_clk_i);
    s = n_seq;
    for (int i = 1; i < 6; i++) put(0, 8'h10 + DATA_W'(i));
    put(0, 8'h20);
    host_valid_i <= 1'b0;
    for (int i = 0; i < 2000 && rdq.size() < 7; i++) @(posedge core_clk_i);
    repeat (20) @(posedge core_clk_i);
    for (int i = 0; i < 6; i++) cmp("read", 8'h10 + DATA_W'(i), rdq[i]);
    cmp("read", 8'h20, rdq[6]);
    cmp("seq err", 8'h01, DATA_W'(n_seq - s));
    cmp("rx avail", 8'h01, DATA_W'(lnk.rx_data_avail_n));
  endtask : t_read

  // Far side stalls until the slave fills, then drains everything
  task automatic t_write();
    tx_ready_i <= 1'b0;
    fork
      begin
        for (int i = 0; i < 6; i++) put(1, 8'hA0 + DATA_W'(i));
        wr_valid_i <= 1'b0;
      end
      begin
        repeat (300) @(posedge core_clk_i);
        cmp("tx space", 8'h01, DATA_W'(lnk.tx_space_avail_n));
        tx_ready_i <= 1'b1;
      end
    join
    for (int i = 0; i < 2000 && txq.size() < 6; i++) @(posedge core_clk_i);
    for (int i = 0; i < 6; i++) cmp("write", 8'hA0 + DATA_W'(i), txq[i]);
    cmp("tx space", 8'h00, DATA_W'(lnk.tx_space_avail_n));
  endtask : t_write

  // Rows: suspend, wake enable, expected resume, expected flush
  task automatic t_wake();
    logic [3:0] tab [3] = '{4'b0001, 4'b1110, 4'b1000};
    int r, f;
    foreach (tab[k])
    begin
      {suspend_i, wake_en_i} <= tab[k][3:2];
      r = n_res;
      f = n_flush;
      repeat (4) @(posedge core_clk_i);
      send_now_i <= 1'b1;
      @(posedge core_clk_i);
      send_now_i <= 1'b0;
      repeat (30) @(posedge core_clk_i);
      bulk_i <= !tab[k][3];
      @(posedge core_clk_i);
      bulk_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      cmp("resume", DATA_W'(tab[k][1]), DATA_W'(n_res - r));
      cmp("flush", DATA_W'(tab[k][0]), DATA_W'(n_flush - f));
    end
  endtask : t_wake

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    t_read();
    t_write();
    t_wake();
    tally_and_finish();
  end

  // Whole run needs under a thousand cycles; this cuts a hang short
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : test_sync_parallel_fifo_link
`default_nettype wire
